// *** cmd_pulse_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module cmd_pulse_model #(
  parameter int HALF = 625
) (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic       dir,
  input  wire logic       pos,
  input  wire logic [7:0] count,
  output logic            fwd_pin,
  output logic            rev_pin,
  output logic            busy
);
  logic       act;
  logic [8:0] left;
  int         ticks;

  // Idle level follows the logic sense; a pulse drives the active level
  assign fwd_pin = (act & ~dir) ^ ~pos;
  assign rev_pin = (act & dir) ^ ~pos;

  initial begin
    busy = 1'b0;
    act = 1'b0;
  end

  // Half period of 625 cycles holds the train at 200 kpps
  always @(posedge clk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      left <= {count, 1'b0};
      ticks <= 0;
    end else if (busy) begin
      if (ticks == HALF - 1) begin
        ticks <= 0;
        act <= ~act;
        left <= left - 9'h001;
        if (left == 9'h001) begin
          busy <= 1'b0;
        end
      end else begin
        ticks <= ticks + 1;
      end
    end
  end
endmodule : cmd_pulse_model

`default_nettype wire

// *** position_loop_defines.svh ***
`ifndef POSITION_LOOP_DEFINES_SVH
`define POSITION_LOOP_DEFINES_SVH

// Register byte offsets
`define OFS_CONTROL        12'h000
`define OFS_GEAR_NUM       12'h004
`define OFS_GEAR_DEN       12'h008
`define OFS_ACCEL_TC       12'h00C
`define OFS_INPOS_WIDTH    12'h010
`define OFS_LOOP_GAIN      12'h014
`define OFS_PULSE_FORMAT   12'h018
`define OFS_IN_FUNC_SEL    12'h01C
`define OFS_OUT_FUNC_SEL   12'h020
`define OFS_STATUS         12'h024
`define OFS_DROOP          12'h028
`define OFS_SPEED_CMD      12'h02C

// Control register fields
`define CTRL_SOFT_CLEAR_BIT 0

// Status register fields
`define STAT_POWER_BIT     0
`define STAT_READY_BIT     1
`define STAT_INPOS_BIT     2
`define STAT_FWD_CLOSED_BIT 3
`define STAT_REV_CLOSED_BIT 4

// Reset values
`define GEAR_NUM_RESET     15'h0001
`define GEAR_DEN_RESET     15'h0001
`define ACCEL_TC_RESET     16'h0000
`define INPOS_WIDTH_RESET  32'h00000064
`define LOOP_GAIN_RESET    16'h0019
`define PULSE_FORMAT_RESET 3'h0
`define IN_FUNC_RESET      8'h00
`define OUT_FUNC_RESET     8'h00

// Terminal function codes
`define FUNC_SERVO_ON      8'h17
`define FUNC_IN_POSITION   8'h24

// Limits
`define GEAR_MAX           15'h7FFF
`define ACCEL_TC_MAX_MS    16'hC350
`define FORMAT_POS_FIRST   3'h3
`define FORMAT_MAX         3'h5

// Timing
`define CLOCK_PERIOD_NS    4
`define READY_DELAY_NS     100000000
`define READY_DELAY_CYCLES (`READY_DELAY_NS / `CLOCK_PERIOD_NS)
`define MS_NS              1000000
`define CYCLES_PER_MS      (`MS_NS / `CLOCK_PERIOD_NS)

`endif

// *** position_loop_pkg.sv ***
package position_loop_pkg;

  typedef enum logic [2:0] {
    SERVO_OFF   = 3'b001,
    SERVO_LOCK  = 3'b010,
    SERVO_READY = 3'b100
  } servo_state_t;

  typedef enum logic [1:0] {
    FMT_SEPARATE   = 2'h0,
    FMT_PULSE_SIGN = 2'h1,
    FMT_QUADRATURE = 2'h2
  } pulse_mode_t;

  typedef logic signed [31:0] droop_t;

endpackage : position_loop_pkg

// *** pulse_train_position_loop.sv ***
// Contract
// - Scaled command pulses add to deviation counter; droop sets speed command.
// - Encoder feedback pulses count the deviation counter down.
// - With no command pulses speed falls with droop, zero droop stops motor.
// - In-position output is high while droop magnitude is below programmed width.
// - Servo-enable works only when the input terminal function code is 23.
// - In-position drives output terminal only when its function code is 36.
// - Servo-enable releases power stage, holds servo lock; ready follows 0.1 s later.
// - Dropping servo-enable shuts the power stage off at once.
// - No command motion in a direction whose stroke-end input is open.
// - Command pulses scaled by numerator over denominator, each 0..32767, default 1.
// - Feedback counts four edges per encoder line.
// - Command rate times gear ratio equals feedback pulse rate of the motor.
// - Steady droop equals command rate over loop gain, default 25 per second.
// - Optional time constant 0..50 s smooths command rate before the loop.
// - Rising edge of clear input zeroes the deviation counter.
// - Format selects separate trains, pulse plus sign, or quadrature; 0-2 negative logic.
//
// Design decisions made here: the APB register port and the address map.
`include "position_loop_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module pulse_train_position_loop #(
  parameter int unsigned READY_DELAY_CYCLES = `READY_DELAY_CYCLES,
  parameter int unsigned CYCLES_PER_MS      = `CYCLES_PER_MS
) (
  input  wire logic        CLOCK_IN,
  input  wire logic        RESET_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output var  logic [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic        SERVO_ENABLE_IN,
  input  wire logic        FWD_STROKE_END_IN,
  input  wire logic        REV_STROKE_END_IN,
  input  wire logic        DROOP_CLEAR_IN,
  input  wire logic        FWD_PULSE_IN,
  input  wire logic        REV_PULSE_IN,
  input  wire logic        ENC_A_IN,
  input  wire logic        ENC_B_IN,
  output var  logic        POWER_ENABLE_OUT,
  output var  logic        READY_OUT,
  output var  logic        IN_POSITION_OUT,
  output var  logic [31:0] SPEED_CMD_OUT
);

  // Returns {step, reverse} for one sample of a quadrature pair, four counts per line
  function automatic logic [1:0] quad_step(input logic pa, input logic pb,
                                           input logic a, input logic b);
    logic [3:0] t;
    t = {pa, pb, a, b};
    case (t)
      4'b0001, 4'b0111, 4'b1110, 4'b1000: quad_step = 2'b10;
      4'b0010, 4'b1011, 4'b1101, 4'b0100: quad_step = 2'b11;
      default:                            quad_step = 2'b00;
    endcase
  endfunction : quad_step

  function automatic logic [31:0] magnitude(input logic signed [31:0] v);
    magnitude = v[31] ? 32'(-v) : 32'(v);
  endfunction : magnitude

  // Configuration registers
  logic [14:0] gear_num_q;
  logic [14:0] gear_den_q;
  logic [15:0] accel_tc_q;
  logic [31:0] inpos_width_q;
  logic [15:0] loop_gain_q;
  logic [2:0]  pulse_format_q;
  logic [7:0]  in_func_q;
  logic [7:0]  out_func_q;
  logic        soft_clear_q;

  logic setup_phase;
  logic access_phase;
  logic addr_hit;
  assign setup_phase  = PSEL_IN && !PENABLE_IN;
  assign access_phase = PSEL_IN && PENABLE_IN;
  always_comb begin
    case (PADDR_IN)
      `OFS_CONTROL, `OFS_GEAR_NUM, `OFS_GEAR_DEN, `OFS_ACCEL_TC, `OFS_INPOS_WIDTH,
      `OFS_LOOP_GAIN, `OFS_PULSE_FORMAT, `OFS_IN_FUNC_SEL, `OFS_OUT_FUNC_SEL,
      `OFS_STATUS, `OFS_DROOP, `OFS_SPEED_CMD: addr_hit = 1'b1;
      default:                                 addr_hit = 1'b0;
    endcase
  end
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = access_phase && !addr_hit;

  logic wr_en;
  assign wr_en = access_phase && PWRITE_IN && addr_hit;

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      gear_num_q     <= `GEAR_NUM_RESET;
      gear_den_q     <= `GEAR_DEN_RESET;
      accel_tc_q     <= `ACCEL_TC_RESET;
      inpos_width_q  <= `INPOS_WIDTH_RESET;
      loop_gain_q    <= `LOOP_GAIN_RESET;
      pulse_format_q <= `PULSE_FORMAT_RESET;
      in_func_q      <= `IN_FUNC_RESET;
      out_func_q     <= `OUT_FUNC_RESET;
      soft_clear_q   <= 1'b0;
    end else begin
      soft_clear_q <= wr_en && (PADDR_IN == `OFS_CONTROL) && PWDATA_IN[`CTRL_SOFT_CLEAR_BIT];
      if (wr_en) begin
        case (PADDR_IN)
          `OFS_GEAR_NUM:     gear_num_q <= PWDATA_IN[14:0];
          `OFS_GEAR_DEN:     gear_den_q <= PWDATA_IN[14:0];
          `OFS_ACCEL_TC: begin
            if (PWDATA_IN[15:0] <= `ACCEL_TC_MAX_MS) begin
              accel_tc_q <= PWDATA_IN[15:0];
            end
          end
          `OFS_INPOS_WIDTH:  inpos_width_q <= PWDATA_IN;
          `OFS_LOOP_GAIN:    loop_gain_q <= PWDATA_IN[15:0];
          `OFS_PULSE_FORMAT: begin
            if (PWDATA_IN[2:0] <= `FORMAT_MAX) begin
              pulse_format_q <= PWDATA_IN[2:0];
            end
          end
          `OFS_IN_FUNC_SEL:  in_func_q <= PWDATA_IN[7:0];
          `OFS_OUT_FUNC_SEL: out_func_q <= PWDATA_IN[7:0];
          default: ;
        endcase
      end
    end
  end

  // Servo sequencing
  position_loop_pkg::servo_state_t state_q;
  logic [31:0] ready_cnt_q;
  logic        servo_req;
  assign servo_req = SERVO_ENABLE_IN && (in_func_q == `FUNC_SERVO_ON);

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      state_q     <= position_loop_pkg::SERVO_OFF;
      ready_cnt_q <= 32'h00000000;
    end else begin
      case (state_q)
        position_loop_pkg::SERVO_OFF: begin
          ready_cnt_q <= 32'h00000000;
          if (servo_req) begin
            state_q <= position_loop_pkg::SERVO_LOCK;
          end
        end
        position_loop_pkg::SERVO_LOCK: begin
          if (!servo_req) begin
            state_q <= position_loop_pkg::SERVO_OFF;
          end else if (ready_cnt_q >= READY_DELAY_CYCLES - 1) begin
            state_q <= position_loop_pkg::SERVO_READY;
          end else begin
            ready_cnt_q <= ready_cnt_q + 32'h00000001;
          end
        end
        position_loop_pkg::SERVO_READY: begin
          if (!servo_req) begin
            state_q <= position_loop_pkg::SERVO_OFF;
          end
        end
        default: state_q <= position_loop_pkg::SERVO_OFF;
      endcase
    end
  end

  logic power_on;
  // Power stage follows the request combinationally so that shut-off is immediate
  assign power_on = servo_req && (state_q != position_loop_pkg::SERVO_OFF);

  // Command pulse decoding
  logic pp_q;
  logic np_q;
  logic pa_q;
  logic pb_q;
  logic ea_q;
  logic eb_q;
  logic clr_in_q;
  logic pp_n;
  logic np_n;
  logic positive_logic;
  position_loop_pkg::pulse_mode_t mode;
  assign positive_logic = (pulse_format_q >= `FORMAT_POS_FIRST);
  assign pp_n = positive_logic ? FWD_PULSE_IN : !FWD_PULSE_IN;
  assign np_n = positive_logic ? REV_PULSE_IN : !REV_PULSE_IN;
  always_comb begin
    case (positive_logic ? 3'(pulse_format_q - `FORMAT_POS_FIRST) : pulse_format_q)
      3'h1:    mode = position_loop_pkg::FMT_PULSE_SIGN;
      3'h2:    mode = position_loop_pkg::FMT_QUADRATURE;
      default: mode = position_loop_pkg::FMT_SEPARATE;
    endcase
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      pp_q     <= 1'b0;
      np_q     <= 1'b0;
      ea_q     <= 1'b0;
      eb_q     <= 1'b0;
      clr_in_q <= 1'b0;
    end else begin
      pp_q     <= pp_n;
      np_q     <= np_n;
      ea_q     <= ENC_A_IN;
      eb_q     <= ENC_B_IN;
      clr_in_q <= DROOP_CLEAR_IN;
    end
  end
  assign pa_q = pp_q;
  assign pb_q = np_q;

  logic [1:0] cmd_quad;
  logic       cmd_step;
  logic       cmd_rev;
  assign cmd_quad = quad_step(pa_q, pb_q, pp_n, np_n);
  always_comb begin
    case (mode)
      position_loop_pkg::FMT_SEPARATE: begin
        cmd_step = (pp_n && !pp_q) || (np_n && !np_q);
        cmd_rev  = np_n && !np_q;
      end
      position_loop_pkg::FMT_PULSE_SIGN: begin
        cmd_step = pp_n && !pp_q;
        cmd_rev  = np_n;
      end
      position_loop_pkg::FMT_QUADRATURE: begin
        cmd_step = cmd_quad[1];
        cmd_rev  = cmd_quad[0];
      end
      default: begin
        cmd_step = 1'b0;
        cmd_rev  = 1'b0;
      end
    endcase
  end

  // Electronic gear: residue gains numerator per pulse, sheds denominator per output
  logic signed [31:0] gear_res_q;
  logic signed [31:0] gear_add;
  logic signed [31:0] gear_sum;
  logic               gear_out;
  logic               gear_out_rev;
  logic               cmd_allowed;
  assign cmd_allowed = cmd_step && power_on &&
                       (cmd_rev ? REV_STROKE_END_IN : FWD_STROKE_END_IN);
  assign gear_add = cmd_allowed ? (cmd_rev ? -32'(gear_num_q) : 32'(gear_num_q)) : 32'sh0;
  assign gear_out = (gear_den_q != 15'h0000) &&
                    (magnitude(gear_res_q) >= 32'(gear_den_q));
  assign gear_out_rev = gear_res_q[31];
  assign gear_sum = gear_res_q + gear_add -
                    (gear_out ? (gear_out_rev ? -32'(gear_den_q) : 32'(gear_den_q)) : 32'sh0);

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN || !power_on) begin
      gear_res_q <= 32'sh0;
    end else begin
      gear_res_q <= gear_sum;
    end
  end

  // Smoothing: pending pulses released at pending/tau per cycle, a first-order lag
  logic signed [31:0] pend_q;
  logic [47:0]        lag_acc_q;
  logic [47:0]        tau_cycles;
  logic [47:0]        lag_sum;
  logic               lag_out;
  logic               smooth_step;
  logic               smooth_rev;
  assign tau_cycles  = 48'(accel_tc_q) * 48'(CYCLES_PER_MS);
  assign lag_sum     = lag_acc_q + 48'(magnitude(pend_q));
  assign lag_out     = (pend_q != 32'sh0) && (lag_sum >= tau_cycles);
  assign smooth_step = (accel_tc_q == 16'h0000) ? gear_out : lag_out;
  assign smooth_rev  = (accel_tc_q == 16'h0000) ? gear_out_rev : pend_q[31];

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN || !power_on || accel_tc_q == 16'h0000) begin
      pend_q    <= 32'sh0;
      lag_acc_q <= 48'h000000000000;
    end else begin
      pend_q <= pend_q + (gear_out ? (gear_out_rev ? -32'sh1 : 32'sh1) : 32'sh0) -
                (lag_out ? (pend_q[31] ? -32'sh1 : 32'sh1) : 32'sh0);
      lag_acc_q <= lag_out ? 48'(lag_sum - tau_cycles) :
                   ((pend_q == 32'sh0) ? 48'h000000000000 : lag_sum);
    end
  end

  // Deviation counter
  position_loop_pkg::droop_t droop_q;
  logic [1:0]                fb;
  logic                      clear_edge;
  assign fb         = quad_step(ea_q, eb_q, ENC_A_IN, ENC_B_IN);
  assign clear_edge = (DROOP_CLEAR_IN && !clr_in_q) || soft_clear_q;

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN || clear_edge || !power_on) begin
      droop_q <= 32'sh0;
    end else begin
      droop_q <= droop_q +
                 (smooth_step ? (smooth_rev ? -32'sh1 : 32'sh1) : 32'sh0) -
                 (fb[1] ? (fb[0] ? -32'sh1 : 32'sh1) : 32'sh0);
    end
  end

  // Speed command in pulses per second: droop times loop gain
  logic signed [47:0] speed_raw;
  logic signed [31:0] speed_d;
  assign speed_raw = 48'(droop_q) * $signed({32'h0, loop_gain_q});
  always_comb begin
    speed_d = speed_raw[31:0];
    if (!power_on) begin
      speed_d = 32'sh0;
    end else if ((!speed_d[31] && !FWD_STROKE_END_IN) || (speed_d[31] && !REV_STROKE_END_IN)) begin
      speed_d = 32'sh0;
    end
  end

  logic in_pos;
  assign in_pos = magnitude(droop_q) < inpos_width_q;

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      POWER_ENABLE_OUT <= 1'b0;
      READY_OUT        <= 1'b0;
      IN_POSITION_OUT  <= 1'b0;
      SPEED_CMD_OUT    <= 32'h00000000;
    end else begin
      POWER_ENABLE_OUT <= power_on;
      READY_OUT        <= servo_req && (state_q == position_loop_pkg::SERVO_READY);
      IN_POSITION_OUT  <= in_pos && (out_func_q == `FUNC_IN_POSITION);
      SPEED_CMD_OUT    <= speed_d;
    end
  end

  // Read data is captured in the setup cycle and held for the access cycle
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      PRDATA_OUT <= 32'h00000000;
    end else if (setup_phase && !PWRITE_IN) begin
      case (PADDR_IN)
        `OFS_GEAR_NUM:     PRDATA_OUT <= {17'h00000, gear_num_q};
        `OFS_GEAR_DEN:     PRDATA_OUT <= {17'h00000, gear_den_q};
        `OFS_ACCEL_TC:     PRDATA_OUT <= {16'h0000, accel_tc_q};
        `OFS_INPOS_WIDTH:  PRDATA_OUT <= inpos_width_q;
        `OFS_LOOP_GAIN:    PRDATA_OUT <= {16'h0000, loop_gain_q};
        `OFS_PULSE_FORMAT: PRDATA_OUT <= {29'h00000000, pulse_format_q};
        `OFS_IN_FUNC_SEL:  PRDATA_OUT <= {24'h000000, in_func_q};
        `OFS_OUT_FUNC_SEL: PRDATA_OUT <= {24'h000000, out_func_q};
        `OFS_STATUS:       PRDATA_OUT <= {27'h0000000, REV_STROKE_END_IN, FWD_STROKE_END_IN,
                                          in_pos, READY_OUT, POWER_ENABLE_OUT};
        `OFS_DROOP:        PRDATA_OUT <= droop_q;
        `OFS_SPEED_CMD:    PRDATA_OUT <= SPEED_CMD_OUT;
        default:           PRDATA_OUT <= 32'h00000000;
      endcase
    end
  end

endmodule : pulse_train_position_loop

`default_nettype wire

// *** pulse_train_position_loop_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none

module pulse_train_position_loop_checker #(
  parameter int unsigned READY_DELAY_CYCLES = 20
) (
  input wire logic        CLOCK_IN,
  input wire logic        RESET_IN,
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PWRITE_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic        PREADY_OUT,
  input wire logic        PSLVERR_OUT,
  input wire logic        SERVO_ENABLE_IN,
  input wire logic        FWD_STROKE_END_IN,
  input wire logic        REV_STROKE_END_IN,
  input wire logic        DROOP_CLEAR_IN,
  input wire logic        POWER_ENABLE_OUT,
  input wire logic        READY_OUT,
  input wire logic [31:0] SPEED_CMD_OUT
);
  logic [31:0] pwr_cnt_q;

  // Cycles the power stage has been released without a break
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN || !POWER_ENABLE_OUT) begin
      pwr_cnt_q <= 32'h00000000;
    end else if (pwr_cnt_q != 32'hFFFFFFFF) begin
      pwr_cnt_q <= pwr_cnt_q + 32'h00000001;
    end
  end

  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (RESET_IN);

  sequence s_access;
    PSEL_IN && PENABLE_IN;
  endsequence
  sequence s_fwd_open;
    !FWD_STROKE_END_IN [*2];
  endsequence
  sequence s_rev_open;
    !REV_STROKE_END_IN [*2];
  endsequence
  sequence s_clear_done;
    ##2 (SPEED_CMD_OUT == 32'h00000000);
  endsequence

  property p_pready;
    PREADY_OUT;
  endproperty
  property p_slverr;
    PSLVERR_OUT |-> s_access;
  endproperty
  property p_rdata_hold;
    !(PSEL_IN && !PENABLE_IN && !PWRITE_IN) |=> $stable(PRDATA_OUT);
  endproperty
  property p_power_off;
    !SERVO_ENABLE_IN |=> !POWER_ENABLE_OUT;
  endproperty
  property p_power_cause;
    $rose(POWER_ENABLE_OUT) |-> $past(SERVO_ENABLE_IN) && $past(SERVO_ENABLE_IN, 2);
  endproperty
  property p_ready_power;
    READY_OUT |-> POWER_ENABLE_OUT;
  endproperty
  property p_ready_early;
    READY_OUT |-> pwr_cnt_q >= READY_DELAY_CYCLES - 3;
  endproperty
  property p_ready_late;
    pwr_cnt_q == READY_DELAY_CYCLES + 3 |-> READY_OUT;
  endproperty
  property p_fwd_stop;
    s_fwd_open |-> $signed(SPEED_CMD_OUT) <= 0;
  endproperty
  property p_rev_stop;
    s_rev_open |-> $signed(SPEED_CMD_OUT) >= 0;
  endproperty
  property p_clear;
    $rose(DROOP_CLEAR_IN) |-> s_clear_done;
  endproperty

  a_pready: assert property (p_pready) else $error("pready low");
  a_slverr: assert property (p_slverr) else $error("pslverr outside access");
  a_rdata_hold: assert property (p_rdata_hold) else $error("prdata moved");
  a_power_off: assert property (p_power_off) else $error("power kept on");
  a_power_cause: assert property (p_power_cause) else $error("power without enable");
  a_ready_power: assert property (p_ready_power) else $error("ready without power");
  a_ready_early: assert property (p_ready_early) else $error("ready too early");
  a_ready_late: assert property (p_ready_late) else $error("ready too late");
  a_fwd_stop: assert property (p_fwd_stop) else $error("forward speed at open end");
  a_rev_stop: assert property (p_rev_stop) else $error("reverse speed at open end");
  a_clear: assert property (p_clear) else $error("speed after clear");
endmodule : pulse_train_position_loop_checker

bind pulse_train_position_loop pulse_train_position_loop_checker #(
  .READY_DELAY_CYCLES(READY_DELAY_CYCLES)
) pulse_train_position_loop_checker_i (
  .CLOCK_IN(CLOCK_IN), .RESET_IN(RESET_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
  .PWRITE_IN(PWRITE_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
  .PSLVERR_OUT(PSLVERR_OUT), .SERVO_ENABLE_IN(SERVO_ENABLE_IN),
  .FWD_STROKE_END_IN(FWD_STROKE_END_IN), .REV_STROKE_END_IN(REV_STROKE_END_IN),
  .DROOP_CLEAR_IN(DROOP_CLEAR_IN), .POWER_ENABLE_OUT(POWER_ENABLE_OUT),
  .READY_OUT(READY_OUT), .SPEED_CMD_OUT(SPEED_CMD_OUT)
);

`default_nettype wire

// *** pulse_train_position_loop_bench.sv ***
`timescale 1ns/10ps
`default_nettype none

module pulse_train_position_loop_bench;
  localparam int RDC = 20;
  localparam int HALF = 625;
  logic        clk, rst, psel, penable, pwrite, servo, fwd_st, rev_st, clr, enc_a, enc_b;
  logic        go, dir, pos, pready, pslverr, fwd_p, rev_p, busy, pwr, rdy, inpos, err;
  logic [7:0]  cnt;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, speed, rd;
  int          n_errors, check_count;

  pulse_train_position_loop #(.READY_DELAY_CYCLES(RDC), .CYCLES_PER_MS(4))
    pulse_train_position_loop_i (
    .CLOCK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .SERVO_ENABLE_IN(servo),
    .FWD_STROKE_END_IN(fwd_st), .REV_STROKE_END_IN(rev_st), .DROOP_CLEAR_IN(clr),
    .FWD_PULSE_IN(fwd_p), .REV_PULSE_IN(rev_p), .ENC_A_IN(enc_a), .ENC_B_IN(enc_b),
    .POWER_ENABLE_OUT(pwr), .READY_OUT(rdy), .IN_POSITION_OUT(inpos), .SPEED_CMD_OUT(speed));

  cmd_pulse_model #(.HALF(HALF)) cmd_pulse_model_i (
    .clk(clk), .go(go), .dir(dir), .pos(pos), .count(cnt),
    .fwd_pin(fwd_p), .rev_pin(rev_p), .busy(busy));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task end_sim;
    if (n_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    check_count++;
    if (got !== ex) begin
      $display("wrong value %s expected %h seen %h", nm, ex, got);
      n_errors++;
    end
  endtask : chk

  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task hang;
    n_errors++;
    end_sim();
  endtask : hang

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd_chk(input string nm, input logic [11:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h00000000);
    chk(nm, ex, rd);
  endtask : rd_chk

  task send(input logic d, input logic [7:0] c);
    int n;
    @(posedge clk);
    dir <= d;
    cnt <= c;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (busy && n < 2 * HALF * (c + 1));
    if (busy) hang();
    tick(8);
  endtask : send

  task wait_rdy(output int n);
    n = 0;
    while (pwr !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    chk("power", 32'h1, {31'h0, pwr});
    n = 0;
    while (rdy !== 1'b1 && n < RDC + 20) begin
      tick(1);
      n++;
    end
    if (rdy !== 1'b1) hang();
  endtask : wait_rdy

  task t_regs;
    chk("outputs", 32'h0, {28'h0, pwr, rdy, inpos, |speed});
    rd_chk("gear_num", 12'h004, 32'h1);
    rd_chk("gear_den", 12'h008, 32'h1);
    rd_chk("accel", 12'h00C, 32'h0);
    rd_chk("width", 12'h010, 32'h64);
    rd_chk("gain", 12'h014, 32'h19);
    apb(1'b0, 12'h030, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    apb(1'b1, 12'h028, 32'h5);
    rd_chk("droop_ro", 12'h028, 32'h0);
    for (int f = 0; f < 7; f++) begin
      apb(1'b1, 12'h018, f);
      rd_chk("format", 12'h018, (f > 5) ? 32'h5 : f);
    end
    apb(1'b1, 12'h018, 32'h3);
  endtask : t_regs

  task t_servo;
    int n;
    servo <= 1'b1;
    tick(10);
    chk("power_unassigned", 32'h0, {31'h0, pwr});
    apb(1'b1, 12'h01C, 32'h17);
    wait_rdy(n);
    chk("ready_delay", 32'h1, {31'h0, (n >= RDC - 4 && n <= RDC + 4)});
    servo <= 1'b0;
    tick(2);
    chk("power_off", 32'h0, {30'h0, pwr, rdy});
    servo <= 1'b1;
    wait_rdy(n);
  endtask : t_servo

  task t_motion;
    fwd_st <= 1'b1;
    rev_st <= 1'b1;
    apb(1'b1, 12'h004, 32'h2);
    send(1'b0, 8'h05);
    rd_chk("droop_fwd", 12'h028, 32'h0000000A);
    chk("speed", 32'h000000FA, speed);
    chk("inpos_unrouted", 32'h0, {31'h0, inpos});
    apb(1'b1, 12'h020, 32'h24);
    tick(3);
    chk("inpos", 32'h1, {31'h0, inpos});
    // B leading A is forward feedback, which counts the droop down
    for (int i = 0; i < 4; i++) begin
      tick(4);
      if (enc_a == enc_b) enc_b <= ~enc_b;
      else enc_a <= ~enc_a;
    end
    tick(4);
    rd_chk("droop_enc", 12'h028, 32'h6);
    apb(1'b1, 12'h010, 32'h5);
    tick(3);
    chk("inpos_wide", 32'h0, {31'h0, inpos});
    send(1'b1, 8'h05);
    rd_chk("droop_rev", 12'h028, 32'hFFFFFFFC);
    chk("inpos_neg", 32'h1, {31'h0, inpos});
  endtask : t_motion

  task t_stroke;
    rev_st <= 1'b0;
    send(1'b1, 8'h03);
    rd_chk("droop_stroke", 12'h028, 32'hFFFFFFFC);
    chk("speed_stroke", 32'h0, speed);
    rev_st <= 1'b1;
    tick(3);
    chk("speed_rev", 32'hFFFFFF9C, speed);
  endtask : t_stroke

  task t_clear;
    clr <= 1'b1;
    tick(3);
    clr <= 1'b0;
    rd_chk("droop_clr", 12'h028, 32'h0);
    chk("speed_clr", 32'h0, speed);
  endtask : t_clear

  task t_neg;
    apb(1'b1, 12'h018, 32'h0);
    pos <= 1'b0;
    tick(4);
    t_clear();
    send(1'b0, 8'h03);
    rd_chk("droop_neg", 12'h028, 32'h6);
  endtask : t_neg

  task t_extra;
    rd_chk("speed_reg", 12'h02C, 32'h00000096);
    apb(1'b1, 12'h000, 32'h00000001);
    rd_chk("droop_soft", 12'h028, 32'h0);
    rd_chk("status", 12'h024, 32'h0000001F);
    apb(1'b1, 12'h008, 32'h00000004);
    send(1'b0, 8'h02);
    rd_chk("droop_den", 12'h028, 32'h1);
    apb(1'b1, 12'h00C, 32'h00000001);
    apb(1'b1, 12'h00C, 32'h0000C351);
    rd_chk("accel_max", 12'h00C, 32'h1);
    send(1'b0, 8'h02);
    rd_chk("droop_accel", 12'h028, 32'h2);
  endtask : t_extra

  initial begin
    {rst, psel, penable, pwrite, servo, fwd_st, rev_st, clr, enc_a, enc_b, go, dir} = 12'h800;
    pos = 1'b1;
    cnt = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    n_errors = 0;
    check_count = 0;
    tick(4);
    rst <= 1'b0;
    tick(1);
    t_regs();
    t_servo();
    t_motion();
    t_stroke();
    t_clear();
    t_neg();
    t_extra();
    end_sim();
  end
endmodule : pulse_train_position_loop_bench

`default_nettype wire
